/* design/rdsbr_pkg.sv */
// shared constants and types of the block-buffer readout link
package rdsbr_pkg;
  localparam int ADDR_BITS    = 8;
  localparam int BLOCK_BITS   = 16;
  localparam int WORD_BITS    = BLOCK_BITS + 2;
  localparam int EMPTY_POS    = 16;
  localparam int FULL_POS     = 17;
  // address byte of a read transfer; value is arbitrary
  localparam logic [7:0] READ_ADDR = 8'h5a;
  localparam int BUF_BLOCKS   = 24;
  localparam int HOST_FIFO    = 8;
  localparam int CLK_MHZ      = 40;
  localparam int CLK_NS       = 25;
  localparam int HOLD_US      = 265;
  localparam int HOLD_CYCLES  = HOLD_US * CLK_MHZ;
  localparam int GUARD_US     = 256;
  localparam int GUARD_CYCLES = GUARD_US * CLK_MHZ;
  localparam int FRAME_MS     = 20;
  localparam int FRAME_CYCLES = FRAME_MS * 1000 * CLK_MHZ;
  localparam int HALF_NS      = 750;
  localparam int HALF_CYCLES  = (HALF_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {DEV_IDLE, DEV_REQ, DEV_BUSY, DEV_HOLD} rdsbr_dev_state_t;
  typedef enum logic [2:0] {
    HST_IDLE, HST_SETUP, HST_LOW, HST_HIGH, HST_DEC, HST_END, HST_GUARD
  } rdsbr_host_state_t;
endpackage

/* design/rdsbr_if.sv */
// serial readout link between the decoder and its host
`timescale 1ns/10ps
interface rdsbr_if;
  logic select;
  logic shift_strobe;
  logic serial_in;
  logic serial_out_o;
  logic serial_out_oe;
  wire  serial_out;
  // open drain with pull-up: low only while the device drives a zero
  assign serial_out = ~(serial_out_oe & ~serial_out_o);
  modport dev (
    input  select,
    input  shift_strobe,
    input  serial_in,
    input  serial_out,
    output serial_out_o,
    output serial_out_oe
  );
  modport host (
    output select,
    output shift_strobe,
    output serial_in,
    input  serial_out
  );
endinterface

/* design/rdsbr_fifo.sv */
// first-in first-out buffer with registered head and flags
`timescale 1ns/10ps
module rdsbr_fifo #(
  parameter int P_WIDTH = 8,
  parameter int P_DEPTH = 8,
  localparam int CW     = $clog2(P_DEPTH + 1)
) (
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_in_valid,
  input  wire logic [P_WIDTH-1:0] i_in_data,
  output logic                    o_in_ready,
  output logic                    o_out_valid,
  output logic      [P_WIDTH-1:0] o_out_data,
  input  wire logic               i_out_ready,
  output logic      [CW-1:0]      o_count
);
  localparam int AW = $clog2(P_DEPTH);

  if (P_DEPTH < 2 || P_WIDTH < 1) begin : g_bad_param
    $error("rdsbr_fifo: depth below 2 or width below 1");
  end

  logic [P_WIDTH-1:0] mem      [P_DEPTH];
  logic [P_WIDTH-1:0] next_mem [P_DEPTH];
  logic [AW-1:0]      wr;
  logic [AW-1:0]      rd;
  logic [AW-1:0]      next_wr;
  logic [AW-1:0]      next_rd;
  logic [CW-1:0]      next_count;
  logic [P_WIDTH-1:0] next_head;
  logic               push;
  logic               pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(P_DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    push       = i_in_valid && o_in_ready;
    pop        = o_out_valid && i_out_ready;
    next_wr    = push ? wrap_inc(wr) : wr;
    next_rd    = pop ? wrap_inc(rd) : rd;
    next_count = o_count + CW'(push) - CW'(pop);
    next_mem   = mem;
    if (push) begin
      next_mem[wr] = i_in_data;
    end
    // head is a register so readers see no memory mux
    next_head = o_out_data;
    if (next_count != '0) begin
      next_head = (push && next_rd == wr) ? i_in_data : mem[next_rd];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mem         <= '{default: '0};
      wr          <= '0;
      rd          <= '0;
      o_count     <= '0;
      o_out_data  <= '0;
      o_out_valid <= 1'b0;
      o_in_ready  <= 1'b1;
    end else begin
      mem         <= next_mem;
      wr          <= next_wr;
      rd          <= next_rd;
      o_count     <= next_count;
      o_out_data  <= next_head;
      o_out_valid <= (next_count != '0);
      o_in_ready  <= (next_count != CW'(P_DEPTH));
    end
  end
endmodule

/* design/rdsbr_device.sv */
// decoder end: block buffer, read request pin and serial readout
`timescale 1ns/10ps
// What this block does
// - each stored block pulls request pin low
// - buffer holds up to 24 blocks
// - pin high 265 us after select falls
// - empty buffer keeps pin high until write
// - leftover data re-requests after hold expires
// - pin high while unsynchronized, low on sync
// - no overwrite within 480 ms window
// - no overwrite within 20 ms re-request window
// - several blocks per frame, frame under 20 ms
// - reads without pending request return zeros
// - host filters other requesters by 256 us
// - transfers open with 8-bit read address
// - transfers only with oscillator running
// - host judges buffer by empty/full flags; host logic reads only the empty flag
module rdsbr_device #(
  parameter int P_DEPTH       = rdsbr_pkg::BUF_BLOCKS,
  parameter int P_HOLD_CYCLES = rdsbr_pkg::HOLD_CYCLES
) (
  input  wire logic                             i_clock,
  input  wire logic                             i_rst,
  input  wire logic                             i_block_valid,
  input  wire logic [rdsbr_pkg::BLOCK_BITS-1:0] i_block_data,
  output logic                                  o_block_ready,
  input  wire logic                             i_sync_reset,
  input  wire logic                             i_synced,
  input  wire logic                             i_osc_running,
  rdsbr_if.dev                                  link
);
  localparam int BB = rdsbr_pkg::BLOCK_BITS;
  localparam int WB = rdsbr_pkg::WORD_BITS;
  localparam int AB = rdsbr_pkg::ADDR_BITS;
  localparam int CW = $clog2(P_DEPTH + 1);
  localparam int TW = 16;

  if (P_DEPTH < 2 || P_HOLD_CYCLES < 1 || P_HOLD_CYCLES >= 2 ** TW) begin : g_bad_param
    $error("rdsbr_device: unsupported depth or hold count");
  end

  // core domain
  rdsbr_pkg::rdsbr_dev_state_t state;
  rdsbr_pkg::rdsbr_dev_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic [WB-1:0] pres;
  logic [WB-1:0] next_pres;
  logic          pres_valid;
  logic          next_pres_valid;
  logic          refresh;
  logic          next_refresh;
  logic          oe;
  logic          next_oe;
  logic          sel_m;
  logic          sel_s;
  logic          bit_m;
  logic          bit_s;
  logic          pop_m;
  logic          pop_s;
  logic          pop_d;
  logic          sync_ok;
  logic          pop_evt;
  logic          fifo_pop;
  logic [BB-1:0] head;
  logic          head_valid;
  logic [CW-1:0] count;
  // link domain
  logic          frame_rst;
  logic [4:0]    edge_cnt;
  logic [4:0]    next_edge_cnt;
  logic [AB-1:0] addr_sh;
  logic [AB-1:0] next_addr_sh;
  logic          addressed;
  logic          next_addressed;
  logic [WB-1:0] tx;
  logic [WB-1:0] next_tx;
  logic          out_bit;
  logic          next_out_bit;
  logic          osc_m;
  logic          osc_s;
  logic          pop_tgl;
  logic          next_pop_tgl;
  logic          load;

  // full buffer refuses new blocks, so a signalled block is never overwritten
  rdsbr_fifo #(
    .P_WIDTH (BB),
    .P_DEPTH (P_DEPTH)
  ) u_buf (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (i_block_valid),
    .i_in_data   (i_block_data),
    .o_in_ready  (o_block_ready),
    .o_out_valid (head_valid),
    .o_out_data  (head),
    .i_out_ready (fifo_pop),
    .o_count     (count)
  );

  function automatic logic [WB-1:0] make_word(input logic v, input logic [BB-1:0] d,
                                              input logic [CW-1:0] c);
    make_word = '0;
    if (v) begin
      make_word[BB-1:0]                = d;
      make_word[rdsbr_pkg::EMPTY_POS]  = (c == CW'(1));
      make_word[rdsbr_pkg::FULL_POS]   = (c == CW'(P_DEPTH));
    end
  endfunction

  assign link.serial_out_o  = 1'b0;
  assign link.serial_out_oe = oe;

  always_comb begin
    sync_ok         = i_synced && !i_sync_reset;
    pop_evt         = pop_s ^ pop_d;
    next_state      = state;
    next_timer      = timer;
    next_pres       = pres;
    next_pres_valid = pres_valid;
    next_refresh    = 1'b0;
    fifo_pop        = 1'b0;
    unique case (state)
      rdsbr_pkg::DEV_IDLE: begin
        if (sync_ok && head_valid) begin
          next_state = rdsbr_pkg::DEV_REQ;
        end
      end
      rdsbr_pkg::DEV_REQ: begin
        if (sel_s) begin
          next_state = rdsbr_pkg::DEV_BUSY;
        end else if (!sync_ok) begin
          next_state = rdsbr_pkg::DEV_IDLE;
        end
      end
      rdsbr_pkg::DEV_BUSY: begin
        if (!sel_s) begin
          next_state = rdsbr_pkg::DEV_HOLD;
          next_timer = TW'(P_HOLD_CYCLES - 1);
        end
      end
      rdsbr_pkg::DEV_HOLD: begin
        if (sel_s) begin
          next_state = rdsbr_pkg::DEV_BUSY;
        end else if (timer == '0) begin
          next_state = rdsbr_pkg::DEV_IDLE;
        end else begin
          next_timer = timer - TW'(1);
        end
      end
    endcase
    // word offered to the link; frozen while a frame runs except after a pop
    if (!sel_s) begin
      next_pres_valid = (state == rdsbr_pkg::DEV_REQ) && head_valid;
      next_pres       = make_word(next_pres_valid, head, count);
    end else if (refresh) begin
      next_pres_valid = head_valid;
      next_pres       = make_word(head_valid, head, count);
    end else if (pop_evt && pres_valid) begin
      fifo_pop     = 1'b1;
      next_refresh = 1'b1;
    end
    next_oe = sel_s ? !bit_s : (state == rdsbr_pkg::DEV_REQ);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state      <= rdsbr_pkg::DEV_IDLE;
      timer      <= '0;
      pres       <= '0;
      pres_valid <= 1'b0;
      refresh    <= 1'b0;
      oe         <= 1'b0;
      sel_m      <= 1'b0;
      sel_s      <= 1'b0;
      bit_m      <= 1'b1;
      bit_s      <= 1'b1;
      pop_m      <= 1'b0;
      pop_s      <= 1'b0;
      pop_d      <= 1'b0;
    end else begin
      state      <= next_state;
      timer      <= next_timer;
      pres       <= next_pres;
      pres_valid <= next_pres_valid;
      refresh    <= next_refresh;
      oe         <= next_oe;
      sel_m      <= link.select;
      sel_s      <= sel_m;
      bit_m      <= out_bit;
      bit_s      <= bit_m;
      pop_m      <= pop_tgl;
      pop_s      <= pop_m;
      pop_d      <= pop_s;
    end
  end

  // link logic runs on the strobe; select low ends every frame by reset.
  // pres is sampled quasi-static: it settles long before the eighth edge.
  assign frame_rst = i_rst || !link.select;

  always_comb begin
    next_edge_cnt  = edge_cnt + 5'h1;
    next_addr_sh   = addr_sh;
    next_addressed = addressed;
    next_tx        = tx;
    next_out_bit   = out_bit;
    next_pop_tgl   = pop_tgl;
    load           = 1'b0;
    if (!addressed && edge_cnt < 5'(AB)) begin
      next_addr_sh = {link.serial_in, addr_sh[AB-1:1]};
      if (edge_cnt == 5'(AB - 1)) begin
        next_addressed = osc_s && (next_addr_sh == rdsbr_pkg::READ_ADDR);
        load           = next_addressed;
      end
    end else if (!addressed) begin
      next_edge_cnt = edge_cnt;
    end else if (edge_cnt == 5'(WB - 1)) begin
      load = 1'b1;
    end else begin
      next_tx      = {1'b1, tx[WB-1:1]};
      next_out_bit = tx[1];
    end
    if (load) begin
      next_tx       = pres;
      next_out_bit  = pres[0];
      next_edge_cnt = '0;
      next_pop_tgl  = !pop_tgl;
    end
  end

  always_ff @(posedge link.shift_strobe or posedge frame_rst) begin
    if (frame_rst) begin
      edge_cnt  <= '0;
      addr_sh   <= '0;
      addressed <= 1'b0;
      tx        <= '1;
      out_bit   <= 1'b1;
      osc_m     <= 1'b0;
      osc_s     <= 1'b0;
    end else begin
      edge_cnt  <= next_edge_cnt;
      addr_sh   <= next_addr_sh;
      addressed <= next_addressed;
      tx        <= next_tx;
      out_bit   <= next_out_bit;
      osc_m     <= i_osc_running;
      osc_s     <= osc_m;
    end
  end

  // the toggle outlives frames so the core never sees a false pop
  always_ff @(posedge link.shift_strobe or posedge i_rst) begin
    if (i_rst) begin
      pop_tgl <= 1'b0;
    end else begin
      pop_tgl <= next_pop_tgl;
    end
  end
endmodule

/* design/rdsbr_host.sv */
// host end: frames readouts on request and queues received words
`timescale 1ns/10ps
module rdsbr_host #(
  parameter int P_FIFO_DEPTH = rdsbr_pkg::HOST_FIFO,
  parameter int P_HALF       = rdsbr_pkg::HALF_CYCLES,
  parameter int P_GUARD      = rdsbr_pkg::GUARD_CYCLES,
  parameter int P_FRAME      = rdsbr_pkg::FRAME_CYCLES
) (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst,
  input  wire logic                            i_osc_running,
  input  wire logic                            i_rx_ready,
  output logic                                 o_rx_valid,
  output logic [rdsbr_pkg::WORD_BITS-1:0]      o_rx_word,
  rdsbr_if.host                                link
);
  localparam int WB       = rdsbr_pkg::WORD_BITS;
  localparam int AB       = rdsbr_pkg::ADDR_BITS;
  localparam int CTW      = 14;
  localparam int ETW      = 20;
  localparam int WORD_CYC = WB * 2 * P_HALF;
  localparam int LIMIT    = P_FRAME - WORD_CYC - 2 * P_HALF;

  if (P_HALF < 1 || P_GUARD < 1 || P_GUARD >= 2 ** CTW || P_HALF >= 2 ** CTW ||
      LIMIT < 1 || P_FRAME >= 2 ** ETW || AB != 8) begin : g_bad_param
    $error("rdsbr_host: unsupported timing parameter");
  end

  rdsbr_pkg::rdsbr_host_state_t state;
  rdsbr_pkg::rdsbr_host_state_t next_state;
  logic [CTW-1:0] cnt;
  logic [CTW-1:0] next_cnt;
  logic [ETW-1:0] elapsed;
  logic [ETW-1:0] next_elapsed;
  logic [4:0]     idx;
  logic [4:0]     next_idx;
  logic [4:0]     ni;
  logic [WB-1:0]  sh;
  logic [WB-1:0]  next_sh;
  logic           sel;
  logic           next_sel;
  logic           strobe;
  logic           next_strobe;
  logic           si;
  logic           next_si;
  logic           push;
  logic           next_push;
  logic           do_m;
  logic           do_s;
  logic           tick;
  logic           fifo_ready;

  // host stalls new frames and words when the user stops draining
  rdsbr_fifo #(
    .P_WIDTH (WB),
    .P_DEPTH (P_FIFO_DEPTH)
  ) u_rx (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .i_in_data   (sh),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_word),
    .i_out_ready (i_rx_ready),
    .o_count     ()
  );

  assign link.select       = sel;
  assign link.shift_strobe = strobe;
  assign link.serial_in    = si;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_idx     = idx;
    next_sh      = sh;
    next_sel     = sel;
    next_strobe  = strobe;
    next_si      = si;
    next_push    = 1'b0;
    next_elapsed = sel ? elapsed + ETW'(1) : '0;
    ni           = idx + 5'h1;
    tick         = (cnt == '0);
    if (!tick) begin
      next_cnt = cnt - CTW'(1);
    end
    unique case (state)
      rdsbr_pkg::HST_IDLE: begin
        if (i_osc_running && !do_s && fifo_ready) begin
          next_state = rdsbr_pkg::HST_SETUP;
          next_sel   = 1'b1;
          next_cnt   = CTW'(P_HALF - 1);
        end
      end
      rdsbr_pkg::HST_SETUP: begin
        if (tick) begin
          next_state = rdsbr_pkg::HST_LOW;
          next_idx   = '0;
          next_si    = rdsbr_pkg::READ_ADDR[0];
          next_cnt   = CTW'(P_HALF - 1);
        end
      end
      rdsbr_pkg::HST_LOW: begin
        if (tick) begin
          if (idx >= 5'(AB)) begin
            next_sh = {do_s, sh[WB-1:1]};
          end
          if (idx == 5'(AB + WB - 1)) begin
            next_state = rdsbr_pkg::HST_DEC;
            // an all-zero word means the device had nothing pending
            next_push  = (next_sh != '0);
            next_cnt   = CTW'(1);
          end else begin
            next_state  = rdsbr_pkg::HST_HIGH;
            next_strobe = 1'b1;
            next_cnt    = CTW'(P_HALF - 1);
          end
        end
      end
      rdsbr_pkg::HST_HIGH: begin
        if (tick) begin
          next_state  = rdsbr_pkg::HST_LOW;
          next_strobe = 1'b0;
          next_idx    = ni;
          next_si     = (ni < 5'(AB)) ? rdsbr_pkg::READ_ADDR[ni[2:0]] : 1'b1;
          next_cnt    = CTW'(P_HALF - 1);
        end
      end
      rdsbr_pkg::HST_DEC: begin
        if (tick) begin
          if (fifo_ready && sh != '0 && !sh[rdsbr_pkg::EMPTY_POS] &&
              elapsed < ETW'(LIMIT)) begin
            next_state  = rdsbr_pkg::HST_HIGH;
            next_strobe = 1'b1;
            next_idx    = 5'(AB - 1);
          end else begin
            next_state = rdsbr_pkg::HST_END;
          end
          next_cnt = CTW'(P_HALF - 1);
        end
      end
      rdsbr_pkg::HST_END: begin
        if (tick) begin
          next_state = rdsbr_pkg::HST_GUARD;
          next_sel   = 1'b0;
          next_cnt   = CTW'(P_GUARD - 1);
        end
      end
      rdsbr_pkg::HST_GUARD: begin
        if (tick) begin
          next_state = rdsbr_pkg::HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state   <= rdsbr_pkg::HST_IDLE;
      cnt     <= '0;
      elapsed <= '0;
      idx     <= '0;
      sh      <= '0;
      sel     <= 1'b0;
      strobe  <= 1'b0;
      si      <= 1'b1;
      push    <= 1'b0;
      do_m    <= 1'b1;
      do_s    <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      elapsed <= next_elapsed;
      idx     <= next_idx;
      sh      <= next_sh;
      sel     <= next_sel;
      strobe  <= next_strobe;
      si      <= next_si;
      push    <= next_push;
      do_m    <= link.serial_out;
      do_s    <= do_m;
    end
  end
endmodule

/* dv/rdsbr_properties.sv */
// concurrent checks on the readout link between decoder and host
`timescale 1ns/10ps
module rdsbr_properties #(
  parameter int P_HOLD  = 50,
  parameter int P_FRAME = 4000
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic select,
  input wire logic shift_strobe,
  input wire logic serial_in,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic serial_out
);
  logic       stb_q;
  logic       next_stb_q;
  int         sel_cnt;
  int         next_sel_cnt;
  int         low_cnt;
  int         next_low_cnt;
  int         rise_cnt;
  int         next_rise_cnt;
  logic [7:0] addr_sr;
  logic [7:0] next_addr_sr;

  always_comb begin
    next_stb_q    = shift_strobe;
    next_sel_cnt  = select ? sel_cnt + 1 : 0;
    next_low_cnt  = select ? 0 : (low_cnt < P_HOLD ? low_cnt + 1 : low_cnt);
    next_rise_cnt = select ? rise_cnt + ((shift_strobe && !stb_q) ? 1 : 0) : 0;
    next_addr_sr  = addr_sr;
    if (select && shift_strobe && !stb_q && rise_cnt < 8) begin
      next_addr_sr = {serial_in, addr_sr[7:1]};
    end
  end

  // low_cnt starts saturated so the hold window is not armed by reset alone
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stb_q    <= 1'b0;
      sel_cnt  <= 0;
      low_cnt  <= P_HOLD;
      rise_cnt <= 0;
      addr_sr  <= 8'h00;
    end else begin
      stb_q    <= next_stb_q;
      sel_cnt  <= next_sel_cnt;
      low_cnt  <= next_low_cnt;
      rise_cnt <= next_rise_cnt;
      addr_sr  <= next_addr_sr;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  property p_open_drain;
    serial_out_oe |-> !serial_out_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("link output driven high");

  property p_start_on_req;
    $rose(select) |-> !serial_out;
  endproperty
  a_start_on_req: assert property (p_start_on_req) else $error("frame opened without request");

  // first cycles after select falls allow for the device's synchroniser
  property p_hold_high;
    !select && low_cnt >= 5 && low_cnt < P_HOLD |-> serial_out;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("request during post-read hold");

  property p_frame_len;
    select |-> sel_cnt < P_FRAME;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("select frame too long");

  property p_addr;
    rise_cnt == 8 && $changed(rise_cnt) |-> addr_sr == rdsbr_pkg::READ_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("wrong address byte");

  property p_after_addr;
    select && rise_cnt >= 9 |-> serial_in;
  endproperty
  a_after_addr: assert property (p_after_addr) else $error("serial input not idle after address");

  property p_strobe_idle;
    !select |-> !shift_strobe;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe active outside frame");

  // bench runs the host with a half phase of 8 cycles
  property p_strobe_half;
    $changed(shift_strobe) |=> $stable(shift_strobe) [*7];
  endproperty
  a_strobe_half: assert property (p_strobe_half) else $error("strobe half phase too short");

  property p_setup;
    $rose(select) |-> !shift_strobe [*8];
  endproperty
  a_setup: assert property (p_setup) else $error("strobe before select setup");

  // host ignores the line for a guard span after each frame
  property p_guard;
    $fell(select) |-> !select [*8];
  endproperty
  a_guard: assert property (p_guard) else $error("frame reopened inside guard");

  c_frame: cover property ($rose(select));
  c_multi: cover property (select && rise_cnt == 30);
  c_req: cover property (!select && $fell(serial_out));
endmodule

/* dv/rds_block_buffer_readout_test.sv */
// self-checking bench: device and host joined by the readout link
`timescale 1ns/10ps
module rds_block_buffer_readout_test;
  localparam int HOLD  = 50;
  localparam int FRAME = 4000;
  localparam int W     = rdsbr_pkg::WORD_BITS;
  localparam int B     = rdsbr_pkg::BLOCK_BITS;
  logic         i_clock;
  logic         i_rst;
  logic         i_block_valid;
  logic [B-1:0] i_block_data;
  logic         o_block_ready;
  logic         i_sync_reset;
  logic         i_synced;
  logic         i_osc_running;
  logic         i_rx_ready;
  logic         o_rx_valid;
  logic [W-1:0] o_rx_word;
  logic [B-1:0] ref_q[$];
  logic [W-1:0] rx_q[$];
  int           err_count;
  int           cmp_count;
  int           n;

  rdsbr_if u_rdsbr_if ();
  rdsbr_device #(.P_HOLD_CYCLES(HOLD)) u_rdsbr_device (
    .i_clock(i_clock), .i_rst(i_rst), .i_block_valid(i_block_valid), .i_block_data(i_block_data),
    .o_block_ready(o_block_ready), .i_sync_reset(i_sync_reset), .i_synced(i_synced),
    .i_osc_running(i_osc_running), .link(u_rdsbr_if));
  rdsbr_host #(.P_HALF(8), .P_GUARD(40), .P_FRAME(FRAME)) u_rdsbr_host (
    .i_clock(i_clock), .i_rst(i_rst), .i_osc_running(i_osc_running), .i_rx_ready(i_rx_ready),
    .o_rx_valid(o_rx_valid), .o_rx_word(o_rx_word), .link(u_rdsbr_if));
  rdsbr_properties #(.P_HOLD(HOLD), .P_FRAME(FRAME)) u_rdsbr_properties (
    .i_clock(i_clock), .i_rst(i_rst), .select(u_rdsbr_if.select), .shift_strobe(u_rdsbr_if.shift_strobe),
    .serial_in(u_rdsbr_if.serial_in), .serial_out_o(u_rdsbr_if.serial_out_o),
    .serial_out_oe(u_rdsbr_if.serial_out_oe), .serial_out(u_rdsbr_if.serial_out));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (o_rx_valid === 1'b1 && i_rx_ready) begin
      rx_q.push_back(o_rx_word);
    end
  end

  task automatic cmp_word(input logic [W-1:0] got, input logic [W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bit got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [W-1:0] exp_word(input logic [B-1:0] d, input int left);
    return {left == rdsbr_pkg::BUF_BLOCKS, left == 1, d};
  endfunction

  // zero blocks are avoided: the host takes an all-zero word for no request
  task automatic put();
    int t;
    logic [B-1:0] d;
    t = 0;
    d = B'($urandom % 32'h0000_ffff) + 16'h0001;
    i_block_valid <= 1'b1;
    i_block_data  <= d;
    @(posedge i_clock);
    while (!o_block_ready && t < 1000) begin
      t++;
      @(posedge i_clock);
    end
    ref_q.push_back(d);
  endtask

  task automatic drain(input int cnt);
    int t;
    t = 0;
    while (rx_q.size() < cnt && t < 30000) begin
      @(posedge i_clock);
      i_rx_ready <= 1'($urandom);
      t++;
    end
    @(posedge i_clock);
    i_rx_ready <= 1'b1;
    cmp_bit(rx_q.size() >= cnt, 1'b1);
    repeat (cnt) begin
      if (rx_q.size() > 0 && ref_q.size() > 0) begin
        cmp_word(rx_q.pop_front(), exp_word(ref_q[0], ref_q.size()));
        void'(ref_q.pop_front());
      end
    end
  endtask

  task automatic quiet(input int cyc);
    logic hi;
    hi = 1'b1;
    repeat (cyc) begin
      @(posedge i_clock);
      hi &= (u_rdsbr_if.serial_out === 1'b1);
    end
    cmp_bit(hi, 1'b1);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // longest path is the 24-block drain with random stalls; limit is far above it
  initial begin
    #1500000;
    err_count++;
    stop_test();
  end

  initial begin
    i_rst = 1'b1;
    i_block_valid = 1'b0;
    i_block_data = 16'h0000;
    i_sync_reset = 1'b0;
    i_synced = 1'b1;
    i_osc_running = 1'b1;
    i_rx_ready = 1'b1;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'h025d));
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    repeat (3) put();
    i_block_valid <= 1'b0;
    drain(3);
    repeat (30) @(posedge i_clock);
    quiet(HOLD + 60);
    $display("test short burst done");
    i_osc_running <= 1'b0;
    repeat (rdsbr_pkg::BUF_BLOCKS) put();
    repeat (20) @(posedge i_clock);
    cmp_bit(o_block_ready, 1'b0);
    cmp_bit(u_rdsbr_if.select, 1'b0);
    i_block_valid <= 1'b0;
    i_osc_running <= 1'b1;
    drain(rdsbr_pkg::BUF_BLOCKS);
    repeat (30) @(posedge i_clock);
    quiet(HOLD + 60);
    $display("test full buffer done");
    i_sync_reset <= 1'b1;
    i_synced <= 1'b0;
    repeat (3) @(posedge i_clock);
    put();
    i_block_valid <= 1'b0;
    quiet(100);
    i_sync_reset <= 1'b0;
    quiet(20);
    i_synced <= 1'b1;
    n = 0;
    while (u_rdsbr_if.serial_out !== 1'b0 && n < 10) begin
      @(posedge i_clock);
      n++;
    end
    cmp_bit(u_rdsbr_if.serial_out, 1'b0);
    drain(1);
    $display("test sync reset done");
    repeat (4) begin
      n = 1 + int'($urandom % 8);
      repeat (n) put();
      i_block_valid <= 1'b0;
      drain(n);
    end
    $display("test random bursts done");
    stop_test();
  end
endmodule
